/* logic/aicc_pkg.sv */
`default_nettype none
package aicc_pkg;
    // register map (indices on the serial register port)
    localparam logic [4:0]  ADDR_RESULT   = 5'h00;
    localparam logic [4:0]  ADDR_OPTIONS  = 5'h04;
    localparam logic [4:0]  ADDR_IRQ      = 5'h05;

    // crc_and_calibration_options field positions
    localparam int          OPT_CRC_FMT   = 3;
    localparam int          OPT_CRC_EN    = 2;
    localparam int          OPT_OFF_EN    = 1;
    localparam int          OPT_GAIN_EN   = 0;
    localparam logic [7:0]  OPT_RST       = 8'h00;
    // bits that enter the settings checksum (read-checksum enable and format masked out)
    localparam logic [7:0]  OPT_CKSUM_MASK = 8'hF3;

    // interrupt_status_control field positions
    localparam int          IRQ_READY     = 6;
    localparam int          IRQ_CFG_OK    = 5;
    localparam int          IRQ_POR       = 4;
    localparam int          IRQ_MODE_HI   = 3;
    localparam int          IRQ_MODE_LO   = 2;
    localparam int          IRQ_FAST      = 1;
    localparam int          IRQ_STP       = 0;
    localparam logic [3:0]  IRQ_CTL_RST   = 4'h3;
    localparam logic        READY_RST     = 1'b1;
    localparam logic        CFG_OK_RST    = 1'b1;
    localparam logic        POR_RST       = 1'b0;

    // checksum engine
    localparam logic [15:0] CRC_POLY      = 16'h8005;
    localparam logic [15:0] CRC_INIT      = 16'h0000;

    // calibration arithmetic: gain 1.0 is 2^23
    localparam int          GAIN_FRAC     = 23;
    localparam logic [23:0] GAIN_UNITY    = 24'h800000;
    localparam logic [23:0] SAT_POS       = 24'h7FFFFF;
    localparam logic [23:0] SAT_NEG       = 24'h800000;

    typedef struct packed {
        logic        vld;
        logic [23:0] data;
    } aicc_sample_t;

    typedef struct packed {
        logic o;
        logic oe;
    } aicc_pin_t;

    typedef enum logic [2:0] {
        TAIL_IDLE,
        TAIL_HI,
        TAIL_LO,
        TAIL_Z1,
        TAIL_Z2
    } aicc_tail_t;
endpackage : aicc_pkg
`default_nettype wire

/* logic/aicc_crc_step.sv */
`default_nettype none
// one byte through the crc-16 shift register, msb first
module aicc_crc_step (
    // state
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data_in,
    // result
    output logic      [15:0] crc_out
);
    always_comb begin
        logic [15:0] c;
        logic        fb;
        c  = crc_in;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            fb = c[15] ^ data_in[i];
            c  = {c[14:0], 1'b0};
            if (fb) begin
                c = c ^ aicc_pkg::CRC_POLY;
            end
        end
        crc_out = c;
    end
endmodule : aicc_crc_step
`default_nettype wire

/* logic/aicc_cal.sv */
`default_nettype none
// digital offset then gain correction, saturating, one cycle latency
module aicc_cal (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // controls
    input  wire logic                 off_en,
    input  wire logic                 gain_en,
    input  wire logic [23:0]          offset,
    input  wire logic [23:0]          gain,
    // samples
    input  wire aicc_pkg::aicc_sample_t raw,
    output aicc_pkg::aicc_sample_t    cal_ff
);
    logic signed [24:0] sum_w;
    logic signed [24:0] off_w;
    logic signed [24:0] gain_w;
    logic signed [49:0] prod_w;
    logic signed [26:0] scaled_w;
    logic               ovf_w;
    logic [23:0]        sat_w;

    assign off_w    = off_en ? $signed({offset[23], offset}) : 25'sh0000000;
    assign sum_w    = $signed({raw.data[23], raw.data}) + off_w;
    assign gain_w   = gain_en ? $signed({1'b0, gain}) : $signed({1'b0, aicc_pkg::GAIN_UNITY});
    assign prod_w   = sum_w * gain_w;
    assign scaled_w = prod_w[49:aicc_pkg::GAIN_FRAC];
    assign ovf_w    = ~((&scaled_w[26:23]) | ~(|scaled_w[26:23]));
    assign sat_w    = ovf_w ? (scaled_w[26] ? aicc_pkg::SAT_NEG : aicc_pkg::SAT_POS) : scaled_w[23:0];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cal_ff <= '0;
        end else begin
            cal_ff.vld  <= raw.vld;
            cal_ff.data <= sat_w;
        end
    end
endmodule : aicc_cal
`default_nettype wire

/* logic/aicc_top.sv */
//Operation
// - The format bit makes the read checksum 32 bits (crc then sixteen zeros) when set and 16 bits when clear.
// - The read-checksum enable bit appends a checksum to read transfers when set and sends none when clear.
// - The settings checksum is computed without the read-checksum enable and format bits.
// - The offset-correction enable bit adds the digital offset to results when set.
// - The gain-correction enable bit scales results by the digital gain when set.
// - The result-ready flag is 0 when a new result waits and 1 after it is read or after reset.
// - The settings-checksum error flag drops to 0 once a checksum mismatch is seen and is 1 otherwise.
// - The power-on flag reads 0 after a power-on reset and is set to 1 by reading the interrupt register.
// - Mode bit high keeps only power-on and checksum-error interrupts on the interrupt pin, with priority.
// - Mode bit low drives the inactive interrupt pin high when set, else leaves it floating.
// - Quick commands are passed on only while the quick-command enable bit is set.
// - The conversion-start indication reaches the interrupt pin only while its enable bit is set.
// - In modulator mode the code stream goes to both the modulator pin and the conversion result.
`default_nettype none
module aicc_top (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // register port from the serial interface
    input  wire logic                   wr_en,
    input  wire logic                   rd_en,
    input  wire logic [4:0]             addr,
    input  wire logic [7:0]             wdata,
    output logic      [23:0]            rdata_ff,
    // read transfer bytes and checksum tail
    input  wire logic                   rd_frame_start,
    input  wire logic                   rd_byte_vld,
    input  wire logic [7:0]             rd_byte,
    input  wire logic                   rd_frame_end,
    input  wire logic                   tail_take,
    output logic                        tail_vld_ff,
    output logic      [7:0]             tail_byte_ff,
    // conversion path
    input  wire aicc_pkg::aicc_sample_t raw_result,
    input  wire logic [23:0]            cal_offset,
    input  wire logic [23:0]            cal_gain,
    input  wire logic                   conv_start,
    input  wire aicc_pkg::aicc_sample_t modulator_word,
    input  wire logic                   modulator_bit,
    output logic      [23:0]            conversion_result_ff,
    // settings integrity
    input  wire logic                   cfg_lock,
    output logic      [15:0]            settings_checksum_ff,
    // quick commands
    input  wire logic                   quick_req,
    input  wire logic [3:0]             quick_code,
    output logic                        quick_go_ff,
    output logic      [3:0]             quick_code_ff,
    // pins
    output aicc_pkg::aicc_pin_t         irq_pin_ff,
    output logic                        modulator_bitstream_ff
);
    // registers
    logic [7:0]           opt_ff;
    logic [3:0]           ctl_ff;
    logic                 result_ready_flag_ff;
    logic                 settings_checksum_error_flag_ff;
    logic                 por_flag_ff;
    logic                 lock_ff;
    logic [15:0]          snap_ff;
    logic [15:0]          comm_crc_ff;
    aicc_pkg::aicc_tail_t tail_ff;

    // decode
    logic wr_opt_w;
    logic wr_irq_w;
    logic rd_res_w;
    logic rd_irq_w;
    logic [7:0] irq_rd_w;
    logic [23:0] nxt_rdata;

    assign wr_opt_w = wr_en & (addr == aicc_pkg::ADDR_OPTIONS);
    assign wr_irq_w = wr_en & (addr == aicc_pkg::ADDR_IRQ);
    assign rd_res_w = rd_en & (addr == aicc_pkg::ADDR_RESULT);
    assign rd_irq_w = rd_en & (addr == aicc_pkg::ADDR_IRQ);
    assign irq_rd_w = {1'b0, result_ready_flag_ff, settings_checksum_error_flag_ff, por_flag_ff, ctl_ff};

    always_comb begin
        if (addr == aicc_pkg::ADDR_RESULT) begin
            nxt_rdata = conversion_result_ff;
        end else if (addr == aicc_pkg::ADDR_OPTIONS) begin
            nxt_rdata = {16'h0000, opt_ff};
        end else if (addr == aicc_pkg::ADDR_IRQ) begin
            nxt_rdata = {16'h0000, irq_rd_w};
        end else begin
            nxt_rdata = 24'h000000;
        end
    end

    // named option and control bits
    logic crc_fmt_w;
    logic crc_en_w;
    logic off_en_w;
    logic gain_en_w;
    logic mode_hi_w;
    logic mode_lo_w;
    logic fast_en_w;
    logic stp_en_w;

    assign crc_fmt_w = opt_ff[aicc_pkg::OPT_CRC_FMT];
    assign crc_en_w  = opt_ff[aicc_pkg::OPT_CRC_EN];
    assign off_en_w  = opt_ff[aicc_pkg::OPT_OFF_EN];
    assign gain_en_w = opt_ff[aicc_pkg::OPT_GAIN_EN];
    assign mode_hi_w = ctl_ff[aicc_pkg::IRQ_MODE_HI];
    assign mode_lo_w = ctl_ff[aicc_pkg::IRQ_MODE_LO];
    assign fast_en_w = ctl_ff[aicc_pkg::IRQ_FAST];
    assign stp_en_w  = ctl_ff[aicc_pkg::IRQ_STP];

    // calibration datapath
    aicc_pkg::aicc_sample_t cal_w;

    aicc_cal u_cal (
        .clk_sys (clk_sys),
        .rst     (rst),
        .off_en  (off_en_w),
        .gain_en (gain_en_w),
        .offset  (cal_offset),
        .gain    (cal_gain),
        .raw     (raw_result),
        .cal_ff  (cal_w)
    );

    // result register: modulator stream replaces conversions in modulator mode
    logic        res_load_w;
    logic [23:0] res_data_w;

    assign res_load_w = mode_hi_w ? modulator_word.vld : cal_w.vld;
    assign res_data_w = mode_hi_w ? modulator_word.data : cal_w.data;

    // settings checksum over the option byte with the read-checksum bits masked, then the control bits
    logic [7:0]  cks_opt_w;
    logic [15:0] cks_mid_w;
    logic [15:0] cks_w;

    assign cks_opt_w = opt_ff & aicc_pkg::OPT_CKSUM_MASK;

    aicc_crc_step u_cks_opt (
        .crc_in  (aicc_pkg::CRC_INIT),
        .data_in (cks_opt_w),
        .crc_out (cks_mid_w)
    );

    aicc_crc_step u_cks_ctl (
        .crc_in  (cks_mid_w),
        .data_in ({4'h0, ctl_ff}),
        .crc_out (cks_w)
    );

    logic lock_rise_w;
    logic cks_bad_w;

    assign lock_rise_w = cfg_lock & ~lock_ff;
    assign cks_bad_w   = lock_ff & cfg_lock & (settings_checksum_ff != snap_ff);

    // read-transfer checksum
    logic [15:0] comm_step_w;
    logic [15:0] nxt_comm_crc;

    aicc_crc_step u_comm (
        .crc_in  (rd_frame_start ? aicc_pkg::CRC_INIT : comm_crc_ff),
        .data_in (rd_byte),
        .crc_out (comm_step_w)
    );

    always_comb begin
        if (rd_byte_vld) begin
            nxt_comm_crc = comm_step_w;
        end else if (rd_frame_start) begin
            nxt_comm_crc = aicc_pkg::CRC_INIT;
        end else begin
            nxt_comm_crc = comm_crc_ff;
        end
    end

    // checksum tail sequencer
    aicc_pkg::aicc_tail_t nxt_tail;
    logic [7:0]           nxt_tail_byte;

    always_comb begin
        nxt_tail = tail_ff;
        case (tail_ff)
            aicc_pkg::TAIL_IDLE: begin
                if (rd_frame_end && crc_en_w) begin
                    nxt_tail = aicc_pkg::TAIL_HI;
                end
            end
            aicc_pkg::TAIL_HI: begin
                if (tail_take) begin
                    nxt_tail = aicc_pkg::TAIL_LO;
                end
            end
            aicc_pkg::TAIL_LO: begin
                if (tail_take) begin
                    nxt_tail = crc_fmt_w ? aicc_pkg::TAIL_Z1 : aicc_pkg::TAIL_IDLE;
                end
            end
            aicc_pkg::TAIL_Z1: begin
                if (tail_take) begin
                    nxt_tail = aicc_pkg::TAIL_Z2;
                end
            end
            aicc_pkg::TAIL_Z2: begin
                if (tail_take) begin
                    nxt_tail = aicc_pkg::TAIL_IDLE;
                end
            end
            default: begin
                nxt_tail = aicc_pkg::TAIL_IDLE;
            end
        endcase
    end

    assign nxt_tail_byte = (nxt_tail == aicc_pkg::TAIL_HI) ? nxt_comm_crc[15:8] :
                           (nxt_tail == aicc_pkg::TAIL_LO) ? nxt_comm_crc[7:0] : 8'h00;

    // interrupt pin
    logic               pend_por_w;
    logic               pend_crc_w;
    logic               pend_dr_w;
    logic               pend_stp_w;
    aicc_pkg::aicc_pin_t nxt_pin;

    assign pend_por_w = ~por_flag_ff;
    assign pend_crc_w = ~settings_checksum_error_flag_ff;
    assign pend_dr_w  = ~result_ready_flag_ff;
    assign pend_stp_w = conv_start & stp_en_w;

    always_comb begin
        if (pend_por_w || pend_crc_w) begin
            nxt_pin = '{o: 1'b0, oe: 1'b1};
        end else if (!mode_hi_w && (pend_dr_w || pend_stp_w)) begin
            nxt_pin = '{o: 1'b0, oe: 1'b1};
        end else begin
            nxt_pin = '{o: 1'b1, oe: mode_lo_w};
        end
    end

    // register file
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            opt_ff <= aicc_pkg::OPT_RST;
            ctl_ff <= aicc_pkg::IRQ_CTL_RST;
        end else begin
            if (wr_opt_w) begin
                opt_ff <= wdata;
            end
            if (wr_irq_w) begin
                ctl_ff <= wdata[3:0];
            end
        end
    end

    // status flags
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            result_ready_flag_ff            <= aicc_pkg::READY_RST;
            settings_checksum_error_flag_ff <= aicc_pkg::CFG_OK_RST;
            por_flag_ff                     <= aicc_pkg::POR_RST;
        end else begin
            if (res_load_w) begin
                result_ready_flag_ff <= 1'b0;
            end else if (rd_res_w) begin
                result_ready_flag_ff <= 1'b1;
            end
            if (cks_bad_w) begin
                settings_checksum_error_flag_ff <= 1'b0;
            end
            if (rd_irq_w) begin
                por_flag_ff <= 1'b1;
            end
        end
    end

    // datapath and checksum state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            conversion_result_ff <= 24'h000000;
            settings_checksum_ff <= aicc_pkg::CRC_INIT;
            snap_ff              <= aicc_pkg::CRC_INIT;
            lock_ff              <= 1'b0;
            comm_crc_ff          <= aicc_pkg::CRC_INIT;
        end else begin
            if (res_load_w) begin
                conversion_result_ff <= res_data_w;
            end
            settings_checksum_ff <= cks_w;
            lock_ff              <= cfg_lock;
            if (lock_rise_w) begin
                snap_ff <= settings_checksum_ff;
            end
            comm_crc_ff <= nxt_comm_crc;
        end
    end

    // outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_ff               <= 24'h000000;
            tail_ff                <= aicc_pkg::TAIL_IDLE;
            tail_vld_ff            <= 1'b0;
            tail_byte_ff           <= 8'h00;
            quick_go_ff            <= 1'b0;
            quick_code_ff          <= 4'h0;
            irq_pin_ff             <= '{o: 1'b1, oe: 1'b0};
            modulator_bitstream_ff <= 1'b0;
        end else begin
            if (rd_en) begin
                rdata_ff <= nxt_rdata;
            end
            tail_ff      <= nxt_tail;
            tail_vld_ff  <= (nxt_tail != aicc_pkg::TAIL_IDLE);
            tail_byte_ff <= nxt_tail_byte;
            quick_go_ff  <= quick_req & fast_en_w;
            if (quick_req && fast_en_w) begin
                quick_code_ff <= quick_code;
            end
            irq_pin_ff             <= nxt_pin;
            modulator_bitstream_ff <= mode_hi_w & modulator_bit;
        end
    end
endmodule : aicc_top
`default_nettype wire

/* tb/aicc_top_assertions.sv */
`default_nettype none
module aicc_top_assertions (
    // clock and reset
    input wire logic                   clk_sys,
    input wire logic                   rst,
    // register port
    input wire logic                   rd_en,
    input wire logic [4:0]             addr,
    input wire logic [23:0]            rdata_ff,
    // checksum tail
    input wire logic                   rd_frame_end,
    input wire logic                   tail_take,
    input wire logic                   tail_vld_ff,
    input wire logic [7:0]             tail_byte_ff,
    // results
    input wire aicc_pkg::aicc_sample_t raw_result,
    input wire aicc_pkg::aicc_sample_t modulator_word,
    input wire logic [23:0]            conversion_result_ff,
    // quick commands and pins
    input wire logic                   quick_req,
    input wire logic [3:0]             quick_code,
    input wire logic                   quick_go_ff,
    input wire logic [3:0]             quick_code_ff,
    input wire aicc_pkg::aicc_pin_t    irq_pin_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire logic irq_rd;
    assign irq_rd = rd_en && (addr == aicc_pkg::ADDR_IRQ);

    chk_por_pin_low: assert property ($past(rst) && !rst |=> !irq_pin_ff.o && irq_pin_ff.oe)
        else $error("interrupt pin not low after reset release");
    chk_por_rearm: assert property (irq_rd ##1 irq_rd |=> rdata_ff[aicc_pkg::IRQ_POR])
        else $error("power-on flag not re-armed by a read");
    chk_irq_upper_zero: assert property (irq_rd |=> rdata_ff[23:7] == 17'h00000)
        else $error("interrupt register upper bits not zero");
    chk_rdata_holds: assert property (!rd_en |=> $stable(rdata_ff))
        else $error("read data moved without a read");
    chk_tail_cause: assert property ($rose(tail_vld_ff) |-> $past(rd_frame_end))
        else $error("checksum tail without frame end");
    chk_tail_holds: assert property (tail_vld_ff && !tail_take |=> tail_vld_ff && $stable(tail_byte_ff))
        else $error("tail byte dropped before taken");
    chk_result_cause: assert property ($changed(conversion_result_ff) |->
        $past(raw_result.vld, 2) || $past(modulator_word.vld))
        else $error("result changed without a sample");
    chk_quick_cause: assert property (quick_go_ff |-> $past(quick_req) && quick_code_ff == $past(quick_code))
        else $error("quick command without request");
    chk_low_is_driven: assert property (!irq_pin_ff.o |-> irq_pin_ff.oe)
        else $error("interrupt pin low while not driven");
endmodule : aicc_top_assertions
`default_nettype wire

/* tb/aicc_host.sv */
`default_nettype none
module aicc_host (
    // device pins
    input wire aicc_pkg::aicc_pin_t irq_pin_ff,
    input wire logic                tail_vld_ff,
    output logic                    tail_take,
    // bench control and view
    input wire logic                stall,
    output logic                    irq_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // board pull-up holds the line when the device lets go
    assign irq_level = irq_pin_ff.oe ? irq_pin_ff.o : 1'b1;
    assign tail_take = tail_vld_ff & ~stall;
endmodule : aicc_host
`default_nettype wire

/* tb/aicc_top_bench.sv */
`default_nettype none
module aicc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst, wr_en, rd_en, rd_frame_start, rd_byte_vld, rd_frame_end, tail_take, tail_vld_ff;
    logic conv_start, modulator_bit, cfg_lock, quick_req, quick_go_ff, modulator_bitstream_ff, stall, irq_level;
    logic [3:0]  quick_code, quick_code_ff;
    logic [4:0]  addr;
    logic [7:0]  wdata, rd_byte, tail_byte_ff;
    logic [15:0] settings_checksum_ff, s;
    logic [23:0] rdata_ff, cal_offset, cal_gain, conversion_result_ff;
    aicc_pkg::aicc_sample_t raw_result, modulator_word;
    aicc_pkg::aicc_pin_t    irq_pin_ff;
    int num_errors, total_checks, cyc;

    aicc_top u_aicc_top (
        .clk_sys, .rst, .wr_en, .rd_en, .addr, .wdata, .rdata_ff, .rd_frame_start, .rd_byte_vld, .rd_byte,
        .rd_frame_end, .tail_take, .tail_vld_ff, .tail_byte_ff, .raw_result, .cal_offset, .cal_gain, .conv_start,
        .modulator_word, .modulator_bit, .conversion_result_ff, .cfg_lock, .settings_checksum_ff, .quick_req,
        .quick_code, .quick_go_ff, .quick_code_ff, .irq_pin_ff, .modulator_bitstream_ff
    );
    aicc_host u_aicc_host (.irq_pin_ff, .tail_vld_ff, .tail_take, .stall, .irq_level);

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask : step

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        step();
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        step();
        wr_en = 1'b0;
    endtask : wr

    task automatic rdc(input logic [4:0] a, input logic [23:0] exp);
        step();
        rd_en = 1'b1;
        addr = a;
        step();
        rd_en = 1'b0;
        chk(rdata_ff, exp);
    endtask : rdc

    function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ aicc_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc8

    task automatic t_regs();
        step();
        chk({irq_pin_ff.oe, irq_pin_ff.o}, 24'h2);
        rd_en = 1'b1;
        addr = aicc_pkg::ADDR_IRQ;
        step();
        chk(rdata_ff, 24'h63);
        step();
        rd_en = 1'b0;
        chk(rdata_ff, 24'h73);
        rdc(aicc_pkg::ADDR_OPTIONS, 24'h0);
        rdc(5'h06, 24'h0);
        wr(aicc_pkg::ADDR_IRQ, 8'hFF);
        rdc(aicc_pkg::ADDR_IRQ, 24'h7F);
        wr(aicc_pkg::ADDR_IRQ, 8'h03);
        step();
        chk({irq_pin_ff.oe, irq_level}, 24'h1);
        wr(aicc_pkg::ADDR_IRQ, 8'h07);
        step();
        chk({irq_pin_ff.oe, irq_pin_ff.o}, 24'h3);
        $display("test registers done");
    endtask : t_regs

    task automatic t_start();
        for (int en = 1; en >= 0; en--) begin
            wr(aicc_pkg::ADDR_IRQ, {7'h01, en[0]});
            conv_start = 1'b1;
            step();
            conv_start = 1'b0;
            chk(irq_level, 24'(!en[0]));
            step();
            chk(irq_level, 24'h1);
        end
        // back to the reset control value so later reads see 0x3 in the low bits
        wr(aicc_pkg::ADDR_IRQ, 8'h03);
        $display("test conversion start done");
    endtask : t_start

    task automatic cal_case(input logic [7:0] opt, input logic [23:0] raw, input logic [23:0] exp);
        wr(aicc_pkg::ADDR_OPTIONS, opt);
        raw_result = {1'b1, raw};
        step();
        raw_result.vld = 1'b0;
        repeat (2) step();
        chk(conversion_result_ff, exp);
        step();
        chk(irq_level, 24'h0);
        rdc(aicc_pkg::ADDR_RESULT, exp);
        rdc(aicc_pkg::ADDR_IRQ, 24'h73);
    endtask : cal_case

    task automatic t_mode();
        wr(aicc_pkg::ADDR_IRQ, 8'h0B);
        modulator_word = {1'b1, 24'h0ABCDE};
        modulator_bit = 1'b1;
        step();
        modulator_word.vld = 1'b0;
        conv_start = 1'b1;
        step();
        conv_start = 1'b0;
        chk(conversion_result_ff, 24'h0ABCDE);
        chk({modulator_bitstream_ff, irq_level}, 24'h3);
        modulator_bit = 1'b0;
        repeat (2) step();
        chk({modulator_bitstream_ff, irq_level}, 24'h1);
        rdc(aicc_pkg::ADDR_RESULT, 24'h0ABCDE);
        $display("test modulator mode done");
    endtask : t_mode

    task automatic t_quick();
        for (int en = 1; en >= 0; en--) begin
            wr(aicc_pkg::ADDR_IRQ, {6'h00, en[0], 1'b1});
            quick_req = 1'b1;
            quick_code = 4'hA;
            step();
            quick_req = 1'b0;
            // a refused command leaves the last accepted code in place
            chk({quick_go_ff, quick_code_ff}, en ? 24'h1A : 24'h0A);
        end
        wr(aicc_pkg::ADDR_IRQ, 8'h03);
        $display("test quick command done");
    endtask : t_quick

    task automatic frame();
        step();
        rd_frame_start = 1'b1;
        step();
        rd_frame_start = 1'b0;
        rd_byte_vld = 1'b1;
        rd_byte = 8'h12;
        step();
        rd_byte = 8'h34;
        step();
        rd_byte_vld = 1'b0;
        rd_frame_end = 1'b1;
        step();
        rd_frame_end = 1'b0;
    endtask : frame

    task automatic t_crc(input logic fmt);
        logic [15:0] c;
        logic [7:0]  q[$];
        c = crc8(crc8(16'h0000, 8'h12), 8'h34);
        wr(aicc_pkg::ADDR_OPTIONS, {4'h0, fmt, 3'h4});
        stall = 1'b1;
        frame();
        repeat (3) step();
        chk(tail_vld_ff, 24'h1);
        q.push_back(tail_byte_ff);
        stall = 1'b0;
        repeat (6) begin
            step();
            if (tail_vld_ff === 1'b1) begin
                q.push_back(tail_byte_ff);
            end
        end
        chk(24'(q.size()), fmt ? 24'h4 : 24'h2);
        chk({q[0], q[1]}, c);
        if (fmt) begin
            chk({q[2], q[3]}, 24'h0);
        end
        $display("test read checksum done");
    endtask : t_crc

    task automatic t_settings();
        wr(aicc_pkg::ADDR_OPTIONS, 8'h00);
        frame();
        chk(tail_vld_ff, 24'h0);
        s = settings_checksum_ff;
        wr(aicc_pkg::ADDR_OPTIONS, 8'h0C);
        repeat (2) step();
        chk(settings_checksum_ff, s);
        wr(aicc_pkg::ADDR_OPTIONS, 8'h00);
        cfg_lock = 1'b1;
        repeat (3) step();
        wr(aicc_pkg::ADDR_OPTIONS, 8'h02);
        repeat (3) step();
        chk(irq_level, 24'h0);
        rdc(aicc_pkg::ADDR_IRQ, 24'h53);
        cfg_lock = 1'b0;
        rst = 1'b1;
        repeat (16) step();
        rst = 1'b0;
        rdc(aicc_pkg::ADDR_IRQ, 24'h63);
        $display("test settings checksum done");
    endtask : t_settings

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            results();
        end
    end

    initial begin
        {rst, cal_offset, cal_gain} = {1'b1, 24'h000005, 24'h400000};
        {wr_en, rd_en, addr, wdata, rd_frame_start, rd_byte_vld, rd_byte, rd_frame_end, raw_result, conv_start,
         modulator_word, modulator_bit, cfg_lock, quick_req, quick_code, stall} = 0;
        repeat (16) step();
        rst = 1'b0;
        t_regs();
        t_start();
        cal_case(8'h02, 24'h000010, 24'h000015);
        cal_case(8'h01, 24'h000020, 24'h000010);
        cal_case(8'h03, 24'h00001B, 24'h000010);
        cal_case(8'h00, 24'h000020, 24'h000020);
        t_mode();
        t_quick();
        t_crc(1'b0);
        t_crc(1'b1);
        t_settings();
        results();
    end
endmodule : aicc_top_bench

bind aicc_top aicc_top_assertions u_aicc_top_assertions (
    .clk_sys, .rst, .rd_en, .addr, .rdata_ff, .rd_frame_end, .tail_take, .tail_vld_ff, .tail_byte_ff,
    .raw_result, .modulator_word, .conversion_result_ff, .quick_req, .quick_code, .quick_go_ff,
    .quick_code_ff, .irq_pin_ff
);
`default_nettype wire
